// ===== hdl/lcsr_cfg.svh
// Constants for the link control and status register zero block.
// Assumes inclusion by bare name from the design files.
`ifndef LCSR_CFG_SVH
`define LCSR_CFG_SVH
// Register index ports and widths
`define LCSR_IDX_LINK_CONTROL_STATUS_ZERO        3'h0
`define LCSR_DATA_W          16
// Field positions
`define LCSR_B_POLL_DEMAND   15
`define LCSR_B_POWERED_OFF_INDICATION          14
`define LCSR_B_TX_DIS        13
`define LCSR_B_RX_DIS        12
`define LCSR_B_TX_ON         11
`define LCSR_B_RX_ON         10
`define LCSR_B_INT_EN        9
`define LCSR_B_INT_FLAG      8
`define LCSR_B_MEM_ERR       7
`define LCSR_B_MISS          6
`define LCSR_B_RX_OVR        5
`define LCSR_B_TX_UND        4
`define LCSR_B_PRIM_EV       3
`define LCSR_B_TX_RING_EV    2
`define LCSR_B_RX_RING_EV    1
// Event field is bits 7..1
`define LCSR_EV_LSB          1
`define LCSR_EV_W            7
// Bus master ready timeout, system clocks
`define LCSR_MEM_TIMEOUT_CYC 256
`define LCSR_TMO_W           9
// Primitive codes
`define LCSR_PRIM_POWER_OFF  6'h00
`define LCSR_PRIM_POWER_ON   6'h01
`endif

// ===== hdl/lcsr_link_control_status_zero.sv
// Link controller control and status register zero with slave port.
// Assumes synchronous host strobes and engine event pulses on i_core_clk.
//
// Overview of operation
// - Demand bit forces immediate transmit ring poll
// - Power-off bit read-only, set by reset/primitive
// - Transmit disable stops ring access after unit
// - Receive disable stops ring access after unit
// - Transmitter-on follows power-on and transmit disable
// - Receiver-on follows power-on and receive disable
// - Interrupt pin low only if enabled and flagged
// - Interrupt enable writable, held clear when off
// - Interrupt flag is OR of event bits except overrun and underrun
// - Memory error after 256 cycles without ready
// - Memory error drops bus, turns link off
// - Missed message sets on no receive buffer
// - Receive overrun sets on full receive FIFO
// - Transmit underrun aborts unit, sets bit
// - Primitive event sets on new provider primitive
// - Transmit ring event sets on entry update
// - Receive ring event sets on entry update
// - Event bits write-one-clear, cleared when off
// - Bit zero always reads zero
// - Index port then value port access
// - Primitive zero enters power-off state
`timescale 1ns/1ns
`default_nettype none
`include "lcsr_cfg.svh"
module lcsr_link_control_status_zero
    import lcsr_pkg::*;
#(
    parameter int TIMEOUT_CYC = `LCSR_MEM_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Host slave port: address select, strobes, data
    input  wire logic        i_sel_index,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    // Primitive issue from the primitive register
    input  wire logic        i_prim_valid,
    input  wire logic [5:0]  i_prim_code,
    // Engine events
    input  wire logic        i_poll_taken,
    input  wire logic        i_tx_idle,
    input  wire logic        i_rx_idle,
    input  wire logic        i_dma_addr_valid,
    input  wire logic        i_dma_ready,
    input  wire logic        i_no_rx_buffer,
    input  wire logic        i_rx_msu_end,
    input  wire logic        i_rx_fifo_full,
    input  wire logic        i_rx_fifo_write,
    input  wire logic        i_tx_fifo_empty,
    input  wire logic        i_tx_shift_empty,
    input  wire logic        i_tx_in_unit,
    input  wire logic        i_prov_prim_written,
    input  wire logic        i_tx_desc_update,
    input  wire logic        i_rx_desc_update,
    // Engine controls
    output logic             o_poll_now,
    output logic             o_tx_ring_en,
    output logic             o_rx_ring_en,
    output logic             o_bus_release,
    output logic             o_rx_discard,
    output logic             o_tx_abort,
    output logic             o_powered_off,
    output logic             o_interrupt_flag_n
);
    // ---------------------------------------------
    // State
    // ---------------------------------------------
    logic [2:0]  index_r;           // Selected register
    logic        poll_demand_r;     // Transmit poll demand
    logic        powered_off_r;     // Power-off phase
    logic        tx_dis_r;          // Transmit ring disable
    logic        rx_dis_r;          // Receive ring disable
    logic        tx_on_r;           // Transmitter on
    logic        rx_on_r;           // Receiver on
    logic        int_en_r;          // Interrupt enable
    logic [6:0]  ev_r;              // Event bits 7..1
    logic [6:0]  ev_set;            // Hardware sets
    logic        mem_tmo;           // Watchdog pulse
    logic        link_control_status_zero_wr;           // Write to register zero
    logic        prim_off;          // Power-off primitive
    logic        prim_on;           // Power-on primitive
    logic        int_flag;          // Interrupt flag

    assign link_control_status_zero_wr  = i_wr && !i_sel_index && (index_r == `LCSR_IDX_LINK_CONTROL_STATUS_ZERO);
    assign prim_off = i_prim_valid && (i_prim_code == `LCSR_PRIM_POWER_OFF);
    assign prim_on  = i_prim_valid && (i_prim_code == `LCSR_PRIM_POWER_ON) && powered_off_r;

    // ---------------------------------------------
    // Bus master watchdog
    // ---------------------------------------------
    lcsr_timeout #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_tmo (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_addr_valid (i_dma_addr_valid),
        .i_ready      (i_dma_ready),
        .o_timeout    (mem_tmo)
    );

    // ---------------------------------------------
    // Index port, kept until rewritten
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            index_r <= 3'h0;
        end else if (i_wr && i_sel_index) begin
            index_r <= i_wdata[3:1];
        end
    end

    // ---------------------------------------------
    // Power-off phase
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            powered_off_r <= 1'b1;
        end else if (prim_off) begin
            powered_off_r <= 1'b1;
        end else if (prim_on) begin
            powered_off_r <= 1'b0;
        end
    end

    // ---------------------------------------------
    // Poll demand: write one sets, use clears
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            poll_demand_r <= 1'b0;
        end else if (link_control_status_zero_wr && i_wdata[`LCSR_B_POLL_DEMAND]) begin
            poll_demand_r <= 1'b1;
        end else if (i_poll_taken || !tx_on_r) begin
            // Demand is dropped when there is no ring to poll
            poll_demand_r <= 1'b0;
        end
    end
    assign o_poll_now = poll_demand_r && tx_on_r;

    // ---------------------------------------------
    // Ring disables, plain read-write
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_dis_r <= 1'b0;
            rx_dis_r <= 1'b0;
        end else if (link_control_status_zero_wr) begin
            tx_dis_r <= i_wdata[`LCSR_B_TX_DIS];
            rx_dis_r <= i_wdata[`LCSR_B_RX_DIS];
        end
    end

    // ---------------------------------------------
    // Transmitter on: off after unit in flight ends
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || prim_off || mem_tmo) begin
            tx_on_r <= 1'b0;
        end else if (!tx_dis_r && prim_on) begin
            tx_on_r <= 1'b1;
        end else if (!powered_off_r && link_control_status_zero_wr && tx_dis_r && !i_wdata[`LCSR_B_TX_DIS]) begin
            // Only a clearing write of a set disable bit, or a power-on primitive, turns it back on, so a memory error sticks
            tx_on_r <= 1'b1;
        end else if (tx_dis_r && i_tx_idle) begin
            tx_on_r <= 1'b0;
        end
    end

    // ---------------------------------------------
    // Receiver on: off after unit in flight ends
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || prim_off || mem_tmo) begin
            rx_on_r <= 1'b0;
        end else if (!rx_dis_r && prim_on) begin
            rx_on_r <= 1'b1;
        end else if (!powered_off_r && link_control_status_zero_wr && rx_dis_r && !i_wdata[`LCSR_B_RX_DIS]) begin
            // Only a clearing write of a set disable bit, or a power-on primitive, turns it back on, so a memory error sticks
            rx_on_r <= 1'b1;
        end else if (rx_dis_r && i_rx_idle) begin
            rx_on_r <= 1'b0;
        end
    end
    // Host may rewrite transmit ring whenever this reads low
    assign o_tx_ring_en = tx_on_r;
    assign o_rx_ring_en = rx_on_r;

    // ---------------------------------------------
    // Interrupt enable
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || powered_off_r) begin
            int_en_r <= 1'b0;
        end else if (link_control_status_zero_wr) begin
            int_en_r <= i_wdata[`LCSR_B_INT_EN];
        end
    end

    // ---------------------------------------------
    // Event bits: set wins over host clear
    // ---------------------------------------------
    assign ev_set = {
        mem_tmo,
        i_no_rx_buffer && i_rx_msu_end && rx_on_r,
        i_rx_fifo_full && i_rx_fifo_write,
        i_tx_fifo_empty && i_tx_shift_empty && i_tx_in_unit,
        i_prov_prim_written,
        i_tx_desc_update,
        i_rx_desc_update
    };

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || prim_off) begin
            ev_r <= 7'h00;
        end else if (link_control_status_zero_wr) begin
            ev_r <= (ev_r & ~i_wdata[7:1]) | ev_set;
        end else begin
            ev_r <= ev_r | ev_set;
        end
    end

    // Underrun and overrun are status only and stay out of the flag
    assign int_flag      = ev_r[6] | ev_r[5] | ev_r[2] | ev_r[1] | ev_r[0];
    assign o_interrupt_flag_n      = !(int_en_r && int_flag);
    assign o_bus_release = mem_tmo;
    assign o_rx_discard  = ev_set[`LCSR_B_RX_OVR-`LCSR_EV_LSB];
    assign o_tx_abort    = ev_set[`LCSR_B_TX_UND-`LCSR_EV_LSB];
    assign o_powered_off = powered_off_r;

    // ---------------------------------------------
    // Read data, registered
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd && i_sel_index) begin
            o_rdata <= {12'h000, index_r, 1'b0};
        end else if (i_rd && index_r == `LCSR_IDX_LINK_CONTROL_STATUS_ZERO) begin
            o_rdata <= {poll_demand_r, powered_off_r, tx_dis_r, rx_dis_r,
                        tx_on_r, rx_on_r, int_en_r, int_flag, ev_r,
                        1'b0};
        end else if (i_rd) begin
            o_rdata <= 16'h0000;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    a_interrupt_flag_pin: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (o_interrupt_flag_n == !(int_en_r && (ev_r[6] | ev_r[5] | ev_r[2] | ev_r[1] | ev_r[0]))))
        else $error("interrupt pin wrong");
    a_ie_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        powered_off_r |=> !int_en_r)
        else $error("enable set while off");
    a_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (ev_set[0] && !prim_off) |=> ev_r[0])
        else $error("event lost");
    a_w1c: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (link_control_status_zero_wr && i_wdata[2] && !ev_set[1]) |=> !ev_r[1])
        else $error("clear failed");
    a_off_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        prim_off |=> (ev_r == 7'h00) && powered_off_r && !tx_on_r)
        else $error("power off incomplete");
    a_memory_timeout_error_link: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        mem_tmo |=> ev_r[6] && !tx_on_r && !rx_on_r)
        else $error("memory error effect");
    a_poll_use: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (poll_demand_r && i_poll_taken && !link_control_status_zero_wr) |=> !poll_demand_r)
        else $error("demand not cleared");
    a_bit_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(i_rd) |=> !o_rdata[0])
        else $error("bit zero set");
    a_txdis_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (tx_dis_r && i_tx_idle && !link_control_status_zero_wr) |=> !tx_on_r)
        else $error("transmitter stays on");
endmodule // lcsr_link_control_status_zero
`default_nettype wire

// ===== hdl/lcsr_pkg.sv
// Types for the link control and status register zero block.
// Assumes lcsr_cfg.svh is on the include path.
package lcsr_pkg;
    // Bus master ready watchdog states
    typedef enum logic [0:0] {LCSR_TMO_IDLE, LCSR_TMO_WAIT} lcsr_tmo_t;
endpackage

// ===== hdl/lcsr_timeout.sv
// Bus master ready watchdog: flags a memory timeout.
// Assumes address strobe and ready are synchronous to the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "lcsr_cfg.svh"
module lcsr_timeout
    import lcsr_pkg::*;
#(
    parameter int TIMEOUT_CYC = `LCSR_MEM_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    // Bus master cycle
    input  wire logic i_addr_valid,
    input  wire logic i_ready,
    // Timeout pulse
    output logic      o_timeout
);
    lcsr_tmo_t                  state_r;   // Watchdog state
    logic [`LCSR_TMO_W-1:0]     count_r;   // Cycles since address
    localparam logic [`LCSR_TMO_W-1:0] LAST = `LCSR_TMO_W'(TIMEOUT_CYC - 1);

    // ---------------------------------------------
    // Count cycles from address until ready
    // ---------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_r   <= LCSR_TMO_IDLE;
            count_r   <= '0;
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= 1'b0;
            unique case (state_r)
                LCSR_TMO_IDLE: begin
                    count_r <= '0;
                    if (i_addr_valid && !i_ready) begin
                        state_r <= LCSR_TMO_WAIT;
                    end
                end
                LCSR_TMO_WAIT: begin
                    if (i_ready) begin
                        state_r <= LCSR_TMO_IDLE;
                    end else if (count_r == LAST) begin
                        // 256 cycles without ready
                        o_timeout <= 1'b1;
                        state_r   <= LCSR_TMO_IDLE;
                    end else begin
                        count_r <= count_r + 1'b1;
                    end
                end
            endcase
        end
    end
endmodule // lcsr_timeout
`default_nettype wire

// ===== test/lcsr_host.sv
// Host processor model driving the slave port of register zero.
// Assumes one bench process calls its tasks, never two at once.
`timescale 1ns/1ns
`default_nettype none
module lcsr_host (
    // Clock
    input  wire logic        i_core_clk,
    // Slave port drive
    output logic             o_sel_index,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_wdata
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial begin
        o_sel_index = 1'b0;
        o_wr        = 1'b0;
        o_rd        = 1'b0;
        o_wdata     = 16'h0000;
    end
    // One write strobe; idle data is inverted so stale values never match
    task automatic put(input logic sel, input logic [15:0] data);
        @(posedge i_core_clk) #1;
        o_sel_index = sel;
        o_wdata     = data;
        o_wr        = 1'b1;
        @(posedge i_core_clk) #1;
        o_wr        = 1'b0;
        o_wdata     = ~data;
    endtask
    // Index first, then value port
    task automatic csr_wr(input logic [2:0] idx, input logic [15:0] data);
        put(1'b1, {12'h000, idx, 1'b0});
        put(1'b0, data);
    endtask
    // Value port read; ring entries are never touched here
    task automatic csr_rd();
        @(posedge i_core_clk) #1;
        o_sel_index = 1'b0;
        o_rd        = 1'b1;
        @(posedge i_core_clk) #1;
        o_rd        = 1'b0;
    endtask
endmodule // lcsr_host
`default_nettype wire

// ===== test/link_ctrl_status_reg_zero_bench.sv
// Self-checking bench for register zero of the link controller.
// Assumes the host model in lcsr_host.sv and a shortened bus timeout.
`timescale 1ns/1ns
`default_nettype none
`include "lcsr_cfg.svh"
module link_ctrl_status_reg_zero_bench import lcsr_pkg::*;;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0;             // Clock, reset
    logic        sel, wr, rd, rd_q = 1'b0;             // Host strobes
    logic [15:0] wdata, rdata;                         // Host data
    logic        pv = 1'b0, poll = 1'b0;               // Primitive, poll
    logic [5:0]  pcode = 6'h00;                        // Primitive code
    logic [9:0]  ev = 10'h000;                         // Engine event lines
    logic        addr_v = 1'b0;                        // Master address
    logic        poll_now, tx_en, rx_en, rel, disc, abrt, powered_off_indication, interrupt_flag_n;
    logic [15:0] exp_q[$];                             // Expected reads
    int          error_cnt = 0, n_tests = 0, cyc = 0;  // Counters
    always #2 clk = ~clk;                              // 250 MHz
    lcsr_host host (.i_core_clk(clk), .o_sel_index(sel), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));
    lcsr_link_control_status_zero #(.TIMEOUT_CYC(8)) DUT (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_sel_index(sel), .i_wr(wr),
        .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .i_prim_valid(pv),
        .i_prim_code(pcode), .i_poll_taken(poll), .i_tx_idle(1'b1),
        .i_rx_idle(1'b1), .i_dma_addr_valid(addr_v), .i_dma_ready(1'b0),
        .i_no_rx_buffer(ev[9]), .i_rx_msu_end(ev[8]), .i_rx_fifo_full(ev[7]),
        .i_rx_fifo_write(ev[6]), .i_tx_fifo_empty(ev[5]),
        .i_tx_shift_empty(ev[4]), .i_tx_in_unit(ev[3]),
        .i_prov_prim_written(ev[2]), .i_tx_desc_update(ev[1]),
        .i_rx_desc_update(ev[0]), .o_poll_now(poll_now), .o_tx_ring_en(tx_en),
        .o_rx_ring_en(rx_en), .o_bus_release(rel), .o_rx_discard(disc),
        .o_tx_abort(abrt), .o_powered_off(powered_off_indication), .o_interrupt_flag_n(interrupt_flag_n));
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask
    task automatic report_and_stop();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Read data lands on the edge that takes the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", rdata, 16'hxxxx);
            end else begin
                check("read data", rdata, exp_q.pop_front());
            end
        end
    end
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    task automatic rd0(input logic [15:0] e);
        exp_q.push_back(e);
        host.csr_rd();
    endtask
    task automatic pulse(input logic [9:0] m, input logic p, input logic [5:0] c);
        @(posedge clk) #1;
        ev    = m;
        pv    = p;
        pcode = c;
        @(posedge clk) #1;
        ev    = 10'h000;
        pv    = 1'b0;
    endtask
    // Event line pattern for status bit k (1..6)
    function automatic logic [9:0] ev_mask(input int k);
        case (k)
            1: return 10'h001;
            2: return 10'h002;
            3: return 10'h004;
            4: return 10'h038;
            5: return 10'h0c0;
            default: return 10'h300;
        endcase
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] b;
        logic [2:0]  r;
        void'($urandom(32'h516dea25));
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        host.csr_wr(3'h0, 16'h0000);
        rd0(16'h4000);
        host.csr_wr(3'h0, 16'h4f01);
        rd0(16'h4000);
        $display("test reset and read-only done");
        pulse(10'h000, 1'b1, `LCSR_PRIM_POWER_ON);
        rd0(16'h0c00);
        host.csr_wr(3'h0, 16'h0200);
        rd0(16'h0e00);
        check("interrupt_flag idle", {15'h0, interrupt_flag_n}, 16'h0001);
        for (int k = 1; k <= 6; k++) begin
            b = 16'h0001 << k;
            pulse(ev_mask(k), 1'b0, 6'h00);
            // Underrun and overrun do not raise the flag
            check("interrupt_flag low", {15'h0, interrupt_flag_n}, (k == 4 || k == 5) ? 16'h0001 : 16'h0000);
            host.csr_wr(3'h0, 16'h0200);
            rd0(((k == 4 || k == 5) ? 16'h0e00 : 16'h0f00) | b);
            host.csr_wr(3'h0, 16'h0200 | b);
            rd0(16'h0e00);
        end
        host.csr_wr(3'h0, 16'h0000);
        pulse(10'h001, 1'b0, 6'h00);
        check("interrupt_flag masked", {15'h0, interrupt_flag_n}, 16'h0001);
        host.csr_wr(3'h0, 16'h0202);
        $display("test events done");
        r = 3'($urandom_range(7, 1));
        host.put(1'b1, {12'h000, r, 1'b0});
        rd0(16'h0000);
        host.put(1'b1, 16'h0000);
        host.csr_wr(3'h0, 16'h8200);
        check("poll now", {15'h0, poll_now}, 16'h0001);
        pulse(10'h000, 1'b0, 6'h00);
        poll = 1'b1;
        @(posedge clk) #1;
        poll = 1'b0;
        @(posedge clk) #1;
        check("poll used", {15'h0, poll_now}, 16'h0000);
        host.csr_wr(3'h0, 16'h3200);
        rd0(16'h3200);
        check("rings off", {14'h0, tx_en, rx_en}, 16'h0000);
        host.csr_wr(3'h0, 16'h0200);
        rd0(16'h0e00);
        $display("test demand and disables done");
        @(posedge clk) #1;
        addr_v = 1'b1;
        b = 16'h0000;
        for (int i = 0; i < 40 && b == 16'h0000; i++) begin
            @(posedge clk) #1;
            b = {15'h0, rel};
        end
        addr_v = 1'b0;
        check("bus release", b, 16'h0001);
        rd0(16'h0380);
        host.csr_wr(3'h0, 16'h0280);
        rd0(16'h0200);
        pulse(10'h002, 1'b1, `LCSR_PRIM_POWER_OFF);
        rd0(16'h4000);
        check("powered off", {15'h0, powered_off_indication}, 16'h0001);
        $display("test timeout and power off done");
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule // link_ctrl_status_reg_zero_bench
`default_nettype wire
